// file: fsm_seq.sv
// Purpose: command sequencer for unsecure, backdoor key and margin commands
// Assumes: single clock, synchronous active-low reset
// Notes:   array erase/verify results and protection come in as pins
`timescale 1ns/1ps
module fsm_seq
  import fsm_pkg::*;
#(
  parameter int ERASE_CYCLES = FSM_ERASE_CYCLES
) (
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic        SPECIAL_MODE,
  input  wire logic [1:0]  KEY_ACCESS_ENABLE_FIELD,
  input  wire logic        SECURE_AT_RESET,
  input  wire logic        ANY_PROTECTED,
  input  wire logic        ERASE_VERIFY_FAIL,
  input  wire logic        ERASE_VERIFY_UNCORR,
  output logic      [17:0] KEY_ADDR,
  input  wire logic [15:0] KEY_DATA,
  output logic             ERASE_ACTIVE,
  output logic             SECURED,
  output logic      [2:0]  PROG_READ_MARGIN,
  output logic      [2:0]  DATA_READ_MARGIN
);

  // ==========================================================================
  // pin synchronisers
  logic [6:0] pin_s1_q;
  logic [6:0] pin_s2_q;
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      pin_s1_q <= 7'h00;
      pin_s2_q <= 7'h00;
    end else begin
      pin_s1_q <= {SPECIAL_MODE, KEY_ACCESS_ENABLE_FIELD, SECURE_AT_RESET,
                   ANY_PROTECTED, ERASE_VERIFY_FAIL, ERASE_VERIFY_UNCORR};
      pin_s2_q <= pin_s1_q;
    end
  end
  logic       special_s;
  logic [1:0] key_access_enable_field_s;
  logic       strap_s;
  logic       prot_s;
  logic       vfail_s;
  logic       vunc_s;
  assign {special_s, key_access_enable_field_s, strap_s, prot_s, vfail_s, vunc_s} = pin_s2_q;

  // ==========================================================================
  // state
  fsm_state_t  state_q;
  logic [2:0]  index_q;
  logic [15:0] param_q [0:7];
  logic        ccf_q;
  logic        acc_q;
  logic        prot_q;
  logic        ver_q;
  logic        unc_q;
  logic        sec_q;
  logic        lock_q;
  logic        strap_done_q;
  logic [2:0]  pmrg_q;
  logic [2:0]  dmrg_q;
  logic [FSM_WAIT_W-1:0] wait_q;
  logic [2:0]  key_ix_q;
  logic        key_bad_q;

  wire [7:0]  cmd_code = param_q[0][15:8];
  wire [1:0]  blk_sel  = param_q[0][1:0];
  wire [15:0] mrg_val  = param_q[1];

  // ==========================================================================
  // bus: writes answer at once; a read waits one cycle so that the registered
  // read data already stands at the edge where waitrequest is seen low
  logic rd_ready_q;
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      rd_ready_q <= 1'b0;
    end else begin
      rd_ready_q <= AVS_READ && !rd_ready_q;
    end
  end
  assign AVS_WAITREQUEST = AVS_READ && !rd_ready_q;
  wire wr       = AVS_WRITE && !AVS_READ;
  wire wr_index = wr && AVS_ADDRESS == FSM_OFS_INDEX && AVS_BYTEENABLE[0];
  wire wr_param = wr && AVS_ADDRESS == FSM_OFS_PARAM && (&AVS_BYTEENABLE[1:0]);
  wire wr_stat  = wr && AVS_ADDRESS == FSM_OFS_STATUS && AVS_BYTEENABLE[0];
  // writes while busy are dropped so a launched command cannot be corrupted
  wire idle     = ccf_q;
  wire launch   = wr_stat && idle && AVS_WRITEDATA[FSM_ST_CCF];
  wire clr_acc  = wr_stat && idle && AVS_WRITEDATA[FSM_ST_ACC];
  wire clr_prot = wr_stat && idle && AVS_WRITEDATA[FSM_ST_PROT];

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (AVS_READ && !rd_ready_q) begin
      unique case (AVS_ADDRESS)
        FSM_OFS_INDEX:  AVS_READDATA <= {29'h0, index_q};
        FSM_OFS_PARAM:  AVS_READDATA <= {16'h0, param_q[index_q]};
        FSM_OFS_STATUS: AVS_READDATA <= {22'h0, lock_q, sec_q, ccf_q, 1'b0, acc_q,
                                         prot_q, 2'h0, ver_q, unc_q};
        FSM_OFS_MARGIN: AVS_READDATA <= {26'h0, dmrg_q, pmrg_q};
        default:        AVS_READDATA <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      index_q <= 3'h0;
    end else if (wr_index && idle) begin
      index_q <= AVS_WRITEDATA[2:0];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (wr_param && idle) begin
      param_q[index_q] <= AVS_WRITEDATA[15:0];
    end
  end

  // ==========================================================================
  // launch checks
  logic launch_err;
  logic is_margin;
  always_comb begin
    is_margin  = cmd_code == FSM_CMD_USER_MRG || cmd_code == FSM_CMD_FLD_MRG;
    launch_err = 1'b0;
    unique case (cmd_code)
      FSM_CMD_UNSECURE: launch_err = index_q != FSM_IX_UNSECURE;
      FSM_CMD_BACKDOOR: launch_err = index_q != FSM_IX_BACKDOOR
                                     || key_access_enable_field_s != FSM_KEY_ACCESS_ENABLE_FIELD_ON
                                     || lock_q;
      FSM_CMD_USER_MRG: launch_err = index_q != FSM_IX_MARGIN
                                     || (blk_sel != FSM_BLK_DATA
                                         && blk_sel != FSM_BLK_PROG)
                                     || mrg_val > FSM_MRG_USER_MAX;
      FSM_CMD_FLD_MRG:  launch_err = !special_s
                                     || index_q != FSM_IX_MARGIN
                                     || (blk_sel != FSM_BLK_DATA
                                         && blk_sel != FSM_BLK_PROG)
                                     || mrg_val > FSM_MRG_FIELD_MAX;
      default:          launch_err = 1'b1;
    endcase
  end

  // ==========================================================================
  // sequencer
  wire erase_end = state_q == FSM_ERASE && wait_q == FSM_WAIT_W'(ERASE_CYCLES - 1);
  wire key_end   = state_q == FSM_KEYCHK && key_ix_q == 3'h4;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      state_q <= FSM_IDLE;
    end else begin
      unique case (state_q)
        FSM_IDLE:   if (launch) state_q <= FSM_LAUNCH;
        FSM_LAUNCH: begin
          if (launch_err || is_margin) state_q <= FSM_DONE;
          else if (cmd_code == FSM_CMD_UNSECURE) state_q <= FSM_ERASE;
          else state_q <= FSM_KEYCHK;
        end
        FSM_ERASE:  if (erase_end) state_q <= FSM_DONE;
        FSM_KEYCHK: if (key_end) state_q <= FSM_DONE;
        FSM_DONE:   state_q <= FSM_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      wait_q <= '0;
    end else if (state_q == FSM_ERASE) begin
      wait_q <= wait_q + 1'b1;
    end else begin
      wait_q <= '0;
    end
  end

  // key index 0..3 compares param 1..4; data is read the cycle after the address
  logic key_vld_q;
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      key_ix_q  <= 3'h0;
      key_vld_q <= 1'b0;
      key_bad_q <= 1'b0;
    end else if (state_q == FSM_KEYCHK) begin
      key_vld_q <= key_ix_q != 3'h4 && !key_vld_q;
      if (key_vld_q) begin
        if (KEY_DATA != param_q[key_ix_q + FSM_IX_KEY0]) key_bad_q <= 1'b1;
        key_ix_q <= key_ix_q + 3'h1;
      end
    end else begin
      key_ix_q  <= 3'h0;
      key_vld_q <= 1'b0;
      key_bad_q <= 1'b0;
    end
  end
  assign KEY_ADDR     = FSM_KEY0_ADDR + {14'h0, key_ix_q[1:0], 1'b0};
  assign ERASE_ACTIVE = state_q == FSM_ERASE;

  // ==========================================================================
  // flags
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      ccf_q <= 1'b1;
    end else if (launch) begin
      ccf_q <= 1'b0;
    end else if (state_q == FSM_DONE) begin
      ccf_q <= 1'b1;
    end
  end

  wire key_fail = key_end && key_bad_q;
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      acc_q <= 1'b0;
    end else if ((state_q == FSM_LAUNCH && launch_err) || key_fail) begin
      acc_q <= 1'b1;
    end else if (clr_acc || launch) begin
      acc_q <= 1'b0;
    end
  end

  wire erase_run = state_q == FSM_LAUNCH && !launch_err && cmd_code == FSM_CMD_UNSECURE;
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      prot_q <= 1'b0;
    end else if (erase_run && prot_s) begin
      prot_q <= 1'b1;
    end else if (clr_prot || launch) begin
      prot_q <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      ver_q <= 1'b0;
      unc_q <= 1'b0;
    end else if (launch) begin
      ver_q <= 1'b0;
      unc_q <= 1'b0;
    end else if (erase_end) begin
      ver_q <= vfail_s || vunc_s;
      unc_q <= vunc_s;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      lock_q <= 1'b0;
    end else if (key_fail) begin
      lock_q <= 1'b1;
    end
  end

  // security strap is caught the first cycle after reset the synchroniser is filled
  logic [1:0] strap_cnt_q;
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      strap_cnt_q  <= 2'h0;
      strap_done_q <= 1'b0;
      sec_q        <= 1'b1;
    end else if (!strap_done_q) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q == 2'h2) begin
        strap_done_q <= 1'b1;
        sec_q        <= strap_s;
      end
    end else if (erase_end && !vfail_s && !vunc_s && !prot_q) begin
      sec_q <= 1'b0;
    end else if (key_end && !key_bad_q) begin
      sec_q <= 1'b0;
    end
  end
  assign SECURED = sec_q;

  // ==========================================================================
  // margin levels
  wire mrg_ok = state_q == FSM_LAUNCH && is_margin && !launch_err;
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      pmrg_q <= FSM_MRG_RESET;
      dmrg_q <= FSM_MRG_RESET;
    end else if (mrg_ok) begin
      if (blk_sel == FSM_BLK_PROG) pmrg_q <= mrg_val[2:0];
      else dmrg_q <= mrg_val[2:0];
    end
  end
  // program level, when set, overrides data reads too
  assign PROG_READ_MARGIN = pmrg_q;
  assign DATA_READ_MARGIN = (pmrg_q != FSM_MRG_RESET) ? pmrg_q : dmrg_q;

  // ==========================================================================
  // checks
  a_ccf_returns: assert property (@(posedge CLOCK) disable iff (!RST_N)
    state_q == FSM_DONE |=> ccf_q)
    else $error("complete flag not set after done");
  a_launch_busy: assert property (@(posedge CLOCK) disable iff (!RST_N)
    launch |=> !ccf_q && state_q == FSM_LAUNCH)
    else $error("complete flag not cleared at launch");
  a_unsec_index: assert property (@(posedge CLOCK) disable iff (!RST_N)
    state_q == FSM_LAUNCH && cmd_code == FSM_CMD_UNSECURE && index_q != 3'h0
    |=> acc_q && state_q == FSM_DONE)
    else $error("unsecure bad index not rejected");
  a_key_index: assert property (@(posedge CLOCK) disable iff (!RST_N)
    state_q == FSM_LAUNCH && cmd_code == FSM_CMD_BACKDOOR && index_q != FSM_IX_BACKDOOR
    |=> acc_q && state_q == FSM_DONE)
    else $error("backdoor bad index not rejected");
  a_verify_keeps: assert property (@(posedge CLOCK) disable iff (!RST_N)
    erase_end && vfail_s |=> ver_q && sec_q == $past(sec_q))
    else $error("verify failure changed security");
  a_prot_flag: assert property (@(posedge CLOCK) disable iff (!RST_N)
    erase_run && prot_s |=> prot_q)
    else $error("protection flag missing");
  a_unc_implies: assert property (@(posedge CLOCK) disable iff (!RST_N)
    unc_q |-> ver_q)
    else $error("uncorrectable without verify error");
  a_key_access_enable_field_gate: assert property (@(posedge CLOCK) disable iff (!RST_N)
    state_q == FSM_LAUNCH && cmd_code == FSM_CMD_BACKDOOR && key_access_enable_field_s != FSM_KEY_ACCESS_ENABLE_FIELD_ON
    |=> acc_q ##1 ccf_q)
    else $error("backdoor ran while disabled");
  a_lock_sticky: assert property (@(posedge CLOCK) disable iff (!RST_N)
    lock_q |=> lock_q)
    else $error("backdoor lock cleared");
  a_key_fail_sec: assert property (@(posedge CLOCK) disable iff (!RST_N)
    key_fail |=> acc_q && lock_q && sec_q == $past(sec_q))
    else $error("key mismatch released security");
  a_field_mode: assert property (@(posedge CLOCK) disable iff (!RST_N)
    state_q == FSM_LAUNCH && cmd_code == FSM_CMD_FLD_MRG && !special_s |=> acc_q)
    else $error("field margin accepted outside special mode");
  a_margin_store: assert property (@(posedge CLOCK) disable iff (!RST_N)
    mrg_ok && blk_sel == FSM_BLK_PROG |=> pmrg_q == $past(mrg_val[2:0]) ##1 ccf_q)
    else $error("margin level not stored");

  c_unsecure_ok: cover property (@(posedge CLOCK) disable iff (!RST_N)
    erase_end && !vfail_s ##1 !sec_q);
  c_key_ok: cover property (@(posedge CLOCK) disable iff (!RST_N)
    key_end && !key_bad_q);
  c_key_lock: cover property (@(posedge CLOCK) disable iff (!RST_N) key_fail);
  c_field_set: cover property (@(posedge CLOCK) disable iff (!RST_N)
    mrg_ok && cmd_code == FSM_CMD_FLD_MRG);
  c_prog_level: cover property (@(posedge CLOCK) disable iff (!RST_N)
    mrg_ok && blk_sel == FSM_BLK_PROG);

endmodule : fsm_seq

// file: fsm_pkg.sv
// Purpose: constants and types for the flash security and margin command sequencer
// Assumes: Avalon-MM register access, 32-bit data, word addressed by byte address
// Notes:   key store and protection are seen through plain ports; block selects are checked against fixed codes
package fsm_pkg;

  // ==========================================================================
  // register map (byte addresses)
  localparam logic [3:0] FSM_OFS_INDEX  = 4'h0;
  localparam logic [3:0] FSM_OFS_PARAM  = 4'h4;
  localparam logic [3:0] FSM_OFS_STATUS = 4'h8;
  localparam logic [3:0] FSM_OFS_MARGIN = 4'hC;

  // ==========================================================================
  // status bit positions
  localparam int FSM_ST_CCF  = 7;
  localparam int FSM_ST_ACC  = 5;
  localparam int FSM_ST_PROT = 4;
  localparam int FSM_ST_VER  = 1;
  localparam int FSM_ST_UNC  = 0;
  localparam int FSM_ST_SEC  = 8;
  localparam int FSM_ST_LOCK = 9;

  // ==========================================================================
  // command codes and parameter indices
  localparam logic [7:0] FSM_CMD_UNSECURE = 8'h0B;
  localparam logic [7:0] FSM_CMD_BACKDOOR = 8'h0C;
  localparam logic [7:0] FSM_CMD_USER_MRG = 8'h0D;
  localparam logic [7:0] FSM_CMD_FLD_MRG  = 8'h0E;
  localparam logic [2:0] FSM_IX_UNSECURE  = 3'h0;
  localparam logic [2:0] FSM_IX_BACKDOOR  = 3'h4;
  localparam logic [2:0] FSM_IX_MARGIN    = 3'h1;
  localparam logic [2:0] FSM_IX_KEY0      = 3'h1;
  localparam logic [1:0] FSM_KEY_ACCESS_ENABLE_FIELD_ON     = 2'h2;
  localparam logic [17:0] FSM_KEY0_ADDR   = 18'h3FF00;

  // margin levels
  localparam logic [15:0] FSM_MRG_USER_MAX  = 16'h0002;
  localparam logic [15:0] FSM_MRG_FIELD_MAX = 16'h0004;
  localparam logic [2:0]  FSM_MRG_RESET     = 3'h0;

  // block selects in bits 1:0 of parameter word 0
  localparam logic [1:0] FSM_BLK_DATA = 2'h1;
  localparam logic [1:0] FSM_BLK_PROG = 2'h3;

  // mass erase and verify duration, cycles
  localparam int FSM_ERASE_CYCLES = 64;
  localparam int FSM_WAIT_W       = 7;

  typedef enum logic [2:0] {
    FSM_IDLE, FSM_LAUNCH, FSM_ERASE, FSM_KEYCHK, FSM_DONE
  } fsm_state_t;

endpackage : fsm_pkg

// file: fsm_testbench.sv
// Purpose: self-checking bench for the flash security and margin command sequencer
// Assumes: writes answer at once; reads hold one wait state and data stand when it ends
// Notes:   erase shortened through ERASE_CYCLES; assertions live in the design files
`timescale 1ns/1ps
module testbench;
  import fsm_pkg::*;
  localparam int ERASE_N = 8;
  logic        clock, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic        special_mode, secure_at_reset, any_protected, verify_fail, verify_uncorr;
  logic [1:0]  key_enable;
  logic [17:0] key_addr, key_ofs;
  logic [15:0] key_data;
  logic        erase_active, secured;
  logic [2:0]  prog_margin, data_margin, exp_pm, exp_dl;
  logic [15:0] key_store [4];
  logic [15:0] words [1:4];
  logic        exp_sec, exp_lock, first_busy, first_erase;
  int          errors, n_compared;

  fsm_seq #(.ERASE_CYCLES(ERASE_N)) dut_u (
    .CLOCK(clock), .RST_N(rst_n), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
    .SPECIAL_MODE(special_mode), .KEY_ACCESS_ENABLE_FIELD(key_enable),
    .SECURE_AT_RESET(secure_at_reset), .ANY_PROTECTED(any_protected),
    .ERASE_VERIFY_FAIL(verify_fail), .ERASE_VERIFY_UNCORR(verify_uncorr),
    .KEY_ADDR(key_addr), .KEY_DATA(key_data), .ERASE_ACTIVE(erase_active),
    .SECURED(secured), .PROG_READ_MARGIN(prog_margin), .DATA_READ_MARGIN(data_margin));

  // ==========================================================================
  // stored key image; outside the four key words the store shows a moving pattern
  assign key_ofs = key_addr - FSM_KEY0_ADDR;
  assign key_data = (key_ofs < 18'h8) ? key_store[key_ofs[2:1]] : ~key_ofs[15:0];

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // ==========================================================================
  // reporting
  task automatic stop_test;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // ==========================================================================
  // bus master: request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      errors++;
      stop_test();
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic pins(input logic prot, input logic vf, input logic vu, input logic sp,
                      input logic [1:0] ke);
    @(posedge clock);
    any_protected <= prot;
    verify_fail <= vf;
    verify_uncorr <= vu;
    special_mode <= sp;
    key_enable <= ke;
    repeat (4) @(posedge clock); // inputs cross a two-flop synchroniser
  endtask : pins

  // loads words 0..ix, launches, then only polls by reads until complete
  task automatic do_cmd(input logic [7:0] cmd, input logic [1:0] blk, input int ix);
    int n;
    for (int i = 0; i <= ix; i++) begin
      bus(1'b1, FSM_OFS_INDEX, 32'(i));
      bus(1'b1, FSM_OFS_PARAM, (i == 0) ? {16'h0, cmd, 6'h0, blk} : {16'h0, words[i]});
    end
    bus(1'b1, FSM_OFS_STATUS, 32'h80);
    bus(1'b0, FSM_OFS_STATUS, 32'h0);
    first_busy = !rd[FSM_ST_CCF];
    first_erase = erase_active;
    n = 0;
    while (rd[FSM_ST_CCF] !== 1'b1 && n < 200) begin
      bus(1'b0, FSM_OFS_STATUS, 32'h0);
      n++;
    end
    if (rd[FSM_ST_CCF] !== 1'b1) begin
      errors++;
      stop_test();
    end
  endtask : do_cmd

  // status bits 9,8,7,5,4,1,0 checked; the rest are not defined
  task automatic chk_st(input logic acc, input logic prot, input logic ver, input logic unc);
    bus(1'b0, FSM_OFS_STATUS, 32'h0);
    chk("status", {22'h0, exp_lock, exp_sec, 2'b10, acc, prot, 2'b00, ver, unc}, rd & 32'h3B3);
    chk("secured", {31'h0, exp_sec}, {31'h0, secured});
  endtask : chk_st

  task automatic do_reset;
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    repeat (6) @(posedge clock);
    exp_sec = 1'b1;
    exp_lock = 1'b0;
    exp_pm = 3'h0;
    exp_dl = 3'h0;
  endtask : do_reset

  // ==========================================================================
  // scenarios
  task automatic sc_unsecure_faults;
    words[1] = 16'h0000;
    do_cmd(FSM_CMD_UNSECURE, 2'h0, 1);
    chk_st(1'b1, 1'b0, 1'b0, 1'b0);
    pins(1'b0, 1'b1, 1'b1, 1'b0, 2'h2);
    do_cmd(FSM_CMD_UNSECURE, 2'h0, 0);
    chk_st(1'b0, 1'b0, 1'b1, 1'b1);
    pins(1'b0, 1'b1, 1'b0, 1'b0, 2'h2);
    do_cmd(FSM_CMD_UNSECURE, 2'h0, 0);
    chk_st(1'b0, 1'b0, 1'b1, 1'b0);
    pins(1'b1, 1'b0, 1'b0, 1'b0, 2'h2);
    do_cmd(FSM_CMD_UNSECURE, 2'h0, 0);
    chk_st(1'b0, 1'b1, 1'b0, 1'b0);
    pins(1'b0, 1'b0, 1'b0, 1'b0, 2'h2);
    do_cmd(8'h3F, 2'h0, 0);
    chk_st(1'b1, 1'b0, 1'b0, 1'b0);
  endtask : sc_unsecure_faults

  task automatic sc_backdoor;
    for (int i = 1; i <= 4; i++) words[i] = key_store[i-1];
    pins(1'b0, 1'b0, 1'b0, 1'b0, 2'h1);
    do_cmd(FSM_CMD_BACKDOOR, 2'h0, 4);
    chk_st(1'b1, 1'b0, 1'b0, 1'b0);
    pins(1'b0, 1'b0, 1'b0, 1'b0, 2'h2);
    do_cmd(FSM_CMD_BACKDOOR, 2'h0, 3);
    chk_st(1'b1, 1'b0, 1'b0, 1'b0);
    words[1] = key_store[1];
    words[2] = key_store[0];
    do_cmd(FSM_CMD_BACKDOOR, 2'h0, 4);
    exp_lock = 1'b1;
    chk_st(1'b1, 1'b0, 1'b0, 1'b0);
    for (int i = 1; i <= 4; i++) words[i] = key_store[i-1];
    do_cmd(FSM_CMD_BACKDOOR, 2'h0, 4);
    chk_st(1'b1, 1'b0, 1'b0, 1'b0);
    do_reset();
    chk_st(1'b0, 1'b0, 1'b0, 1'b0);
    do_cmd(FSM_CMD_BACKDOOR, 2'h0, 4); // launched by the bench, not from the key block
    exp_sec = 1'b0;
    chk_st(1'b0, 1'b0, 1'b0, 1'b0);
    do_reset();
  endtask : sc_backdoor

  task automatic sc_unsecure_ok;
    do_cmd(FSM_CMD_UNSECURE, 2'h0, 0);
    chk("busy after launch", 32'h1, {31'h0, first_busy});
    chk("erase active", 32'h1, {31'h0, first_erase});
    exp_sec = 1'b0;
    chk_st(1'b0, 1'b0, 1'b0, 1'b0);
  endtask : sc_unsecure_ok

  task automatic margin(input logic [7:0] cmd, input logic [1:0] blk, input logic [15:0] lvl,
                        input int ix, input logic ok);
    words[1] = lvl;
    do_cmd(cmd, blk, ix);
    chk_st(!ok, 1'b0, 1'b0, 1'b0);
    if (ok && blk == FSM_BLK_PROG) exp_pm = lvl[2:0];
    if (ok && blk == FSM_BLK_DATA) exp_dl = lvl[2:0];
    chk("prog margin", {29'h0, exp_pm}, {29'h0, prog_margin});
    chk("data margin", {29'h0, (exp_pm != 3'h0) ? exp_pm : exp_dl}, {29'h0, data_margin});
    bus(1'b0, FSM_OFS_MARGIN, 32'h0);
    chk("margin register", {26'h0, exp_dl, exp_pm}, rd);
    bus(1'b0, FSM_OFS_INDEX, 32'h0);
    chk("index register", 32'(ix), rd);
  endtask : margin

  task automatic sc_margins;
    for (int l = 0; l < 4; l++) begin
      margin(FSM_CMD_USER_MRG, FSM_BLK_DATA, 16'(l), 1, l <= 2);
    end
    margin(FSM_CMD_USER_MRG, FSM_BLK_PROG, 16'h0001, 1, 1'b1);
    margin(FSM_CMD_USER_MRG, FSM_BLK_PROG, 16'h0000, 1, 1'b1);
    margin(FSM_CMD_USER_MRG, 2'h0, 16'h0001, 1, 1'b0);
    margin(FSM_CMD_USER_MRG, FSM_BLK_DATA, 16'h0001, 2, 1'b0);
    margin(FSM_CMD_FLD_MRG, FSM_BLK_DATA, 16'h0003, 1, 1'b0);
    pins(1'b0, 1'b0, 1'b0, 1'b1, 2'h2);
    for (int l = 0; l < 6; l++) begin
      margin(FSM_CMD_FLD_MRG, FSM_BLK_DATA, 16'(l), 1, l <= 4);
    end
    margin(FSM_CMD_FLD_MRG, FSM_BLK_PROG, 16'h0004, 1, 1'b1);
    margin(FSM_CMD_FLD_MRG, FSM_BLK_PROG, 16'h0002, 0, 1'b0);
  endtask : sc_margins

  // ==========================================================================
  // main sequence
  initial begin
    errors = 0;
    n_compared = 0;
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    special_mode = 1'b0;
    secure_at_reset = 1'b1;
    any_protected = 1'b0;
    verify_fail = 1'b0;
    verify_uncorr = 1'b0;
    key_enable = 2'h2;
    key_store = '{16'h1A2B, 16'h3C4D, 16'h5E6F, 16'h7081};
    do_reset();
    chk_st(1'b0, 1'b0, 1'b0, 1'b0);
    chk("margins at reset", 32'h0, {26'h0, prog_margin, data_margin});
    sc_unsecure_faults();
    sc_backdoor();
    sc_unsecure_ok();
    sc_margins();
    stop_test();
  end
endmodule : testbench
